// File: hw/hub_cfg_pkg.sv
/*
 * Constants, encodings and carrier types for the hub configuration register set.
 * Assumes a single 25 MHz system clock and a byte-wide configuration access path
 * that is driven either by an SMBus slave front end or by an EEPROM loader.
 */
// Behaviour
// - Every mapped register is readable and writable over SMBus.
// - External loading starts every register at zero.
// - Same register set for SMBus and EEPROM.
// - Status/command byte is SMBus only.
// - Vendor identifier is low byte then high.
// - Product identifier is low byte then high.
// - BCD release number is low byte then high.
// - Identifier bytes come from the selected source.
// - Charge enable bit n powers port n. The code powers port n from bit n+1.
// - Select pins after reset choose the source.
// - Straps ignored under SMBus or EEPROM configuration.
package hub_cfg_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int MAP_SIZE = 256;
	localparam int NUM_PORTS = 4;

	// Clock and the wait that lets the select pins pass their synchroniser
	localparam int CLK_HZ = 25000000;
	localparam int SETTLE_NS = 120;
	localparam logic [3:0] SETTLE_CYCLES = 4'((SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000);

	localparam logic [7:0] OFF_VENDOR_ID_LOW = 8'h00;
	localparam logic [7:0] OFF_VENDOR_ID_HIGH = 8'h01;
	localparam logic [7:0] OFF_PRODUCT_ID_LOW = 8'h02;
	localparam logic [7:0] OFF_PRODUCT_ID_HIGH = 8'h03;
	localparam logic [7:0] OFF_RELEASE_NUMBER_LOW = 8'h04;
	localparam logic [7:0] OFF_RELEASE_NUMBER_HIGH = 8'h05;
	localparam logic [7:0] OFF_CONFIG_BYTE_ONE = 8'h06;
	localparam logic [7:0] OFF_CONFIG_BYTE_TWO = 8'h07;
	localparam logic [7:0] OFF_CONFIG_BYTE_THREE = 8'h08;
	localparam logic [7:0] OFF_FIXED_ATTACH_PORTS = 8'h09;
	localparam logic [7:0] OFF_PORT_OFF_SELF_POWERED = 8'h0a;
	localparam logic [7:0] OFF_PORT_OFF_BUS_POWERED = 8'h0b;
	localparam logic [7:0] OFF_POWER_BUDGET_SELF = 8'h0c;
	localparam logic [7:0] OFF_POWER_BUDGET_BUS = 8'h0d;
	localparam logic [7:0] OFF_CONTROLLER_CURRENT_SELF = 8'h0e;
	localparam logic [7:0] OFF_CONTROLLER_CURRENT_BUS = 8'h0f;
	localparam logic [7:0] OFF_PORT_POWER_SETTLE_TIME = 8'h10;
	localparam logic [7:0] OFF_LANGUAGE_CODE_HIGH = 8'h11;
	localparam logic [7:0] OFF_LANGUAGE_CODE_LOW = 8'h12;
	localparam logic [7:0] OFF_MAKER_TEXT_LENGTH = 8'h13;
	localparam logic [7:0] OFF_PRODUCT_TEXT_LENGTH = 8'h14;
	localparam logic [7:0] OFF_SERIAL_TEXT_LENGTH = 8'h15;
	localparam logic [7:0] OFF_MAKER_TEXT_AREA = 8'h16;
	localparam logic [7:0] OFF_PRODUCT_TEXT_AREA = 8'h54;
	localparam logic [7:0] OFF_SERIAL_TEXT_AREA = 8'h92;
	localparam logic [7:0] OFF_SERIAL_TEXT_LAST = 8'hcf;
	localparam logic [7:0] OFF_CHARGE_PORT_ENABLE = 8'hd0;
	localparam logic [7:0] OFF_RESERVED_E0 = 8'he0;
	localparam logic [7:0] OFF_RESERVED_F5 = 8'hf5;
	localparam logic [7:0] OFF_UPSTREAM_DRIVE_STRENGTH = 8'hf6;
	localparam logic [7:0] OFF_RESERVED_F7 = 8'hf7;
	localparam logic [7:0] OFF_DOWNSTREAM_DRIVE_STRENGTH = 8'hf8;
	localparam logic [7:0] OFF_RESERVED_F9 = 8'hf9;
	localparam logic [7:0] OFF_PAIR_POLARITY_SWAP = 8'hfa;
	localparam logic [7:0] OFF_LOGICAL_PORT_REMAP_A = 8'hfb;
	localparam logic [7:0] OFF_LOGICAL_PORT_REMAP_B = 8'hfc;
	localparam logic [7:0] OFF_RESERVED_FD = 8'hfd;
	localparam logic [7:0] OFF_RESERVED_FE = 8'hfe;
	localparam logic [7:0] OFF_SMBUS_STATE_AND_COMMAND = 8'hff;

	// Internal defaults; the identity defaults are arbitrary values
	localparam logic [7:0] DEF_VENDOR_ID_LOW = 8'h5a;
	localparam logic [7:0] DEF_VENDOR_ID_HIGH = 8'ha5;
	localparam logic [7:0] DEF_PRODUCT_ID_LOW = 8'h3c;
	localparam logic [7:0] DEF_PRODUCT_ID_HIGH = 8'hc3;
	localparam logic [7:0] DEF_RELEASE_NUMBER_LOW = 8'h01;
	localparam logic [7:0] DEF_RELEASE_NUMBER_HIGH = 8'h00;
	localparam logic [7:0] DEF_CONFIG_BYTE_ONE = 8'h9b;
	localparam logic [7:0] DEF_CONFIG_BYTE_TWO = 8'h20;
	localparam logic [7:0] DEF_CONFIG_BYTE_THREE = 8'h02;
	localparam logic [7:0] DEF_POWER_BUDGET_SELF = 8'h01;
	localparam logic [7:0] DEF_POWER_BUDGET_BUS = 8'h32;
	localparam logic [7:0] DEF_CONTROLLER_CURRENT_SELF = 8'h01;
	localparam logic [7:0] DEF_CONTROLLER_CURRENT_BUS = 8'h32;
	localparam logic [7:0] DEF_PORT_POWER_SETTLE_TIME = 8'h32;
	localparam logic [7:0] DEF_ZERO = 8'h00;
	localparam int SELF_POWER_BIT = 7;

	typedef enum logic [1:0] {
		SRC_INTERNAL = 2'h0,
		SRC_SMBUS = 2'h1,
		SRC_BUS_POWERED = 2'h2,
		SRC_EEPROM = 2'h3
	} cfg_source_type;

	typedef enum logic [2:0] {
		ST_SETTLE = 3'h1,
		ST_APPLY = 3'h2,
		ST_RUN = 3'h4
	} init_state_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} cfg_request_type;

	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] rdata;
	} cfg_answer_type;

	typedef struct packed {
		logic [15:0] vendor_id;
		logic [15:0] product_id;
		logic [15:0] release_number;
	} identity_type;

	typedef struct packed {
		logic [7:0] config_byte_one;
		logic [7:0] config_byte_two;
		logic [7:0] config_byte_three;
		logic [7:0] fixed_attach_ports;
		logic [7:0] port_off_self_powered;
		logic [7:0] port_off_bus_powered;
		logic [7:0] power_budget_self;
		logic [7:0] power_budget_bus;
		logic [7:0] controller_current_self;
		logic [7:0] controller_current_bus;
		logic [7:0] port_power_settle_time;
		logic [15:0] language_code;
		logic [7:0] upstream_drive_strength;
		logic [7:0] downstream_drive_strength;
		logic [7:0] pair_polarity_swap;
		logic [7:0] logical_port_remap_a;
		logic [7:0] logical_port_remap_b;
		logic [7:0] smbus_state_and_command;
	} hub_settings_type;

endpackage

// File: hw/hub_config_register_set.sv
/*
 * Byte-wide configuration register set of the hub controller, with source
 * selection after reset, internal defaults, strap handling and port power.
 * Assumes the access request comes from SMBus slave or EEPROM loader logic on
 * clk_sys; select and strap pins are asynchronous and synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none

module hub_config_register_set (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [1:0] config_select_pin,
	input wire logic [hub_cfg_pkg::NUM_PORTS-1:0] strap_charge_pin,
	input wire hub_cfg_pkg::cfg_request_type request,
	output hub_cfg_pkg::cfg_answer_type answer,
	output hub_cfg_pkg::identity_type identity,
	output hub_cfg_pkg::hub_settings_type settings,
	output logic [hub_cfg_pkg::NUM_PORTS-1:0] port_power_out,
	output logic config_done,
	output hub_cfg_pkg::cfg_source_type config_source
);

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers

	function automatic logic is_mapped(input logic [7:0] addr);
		logic hit;
		hit = 1'b0;
		if (addr <= hub_cfg_pkg::OFF_CHARGE_PORT_ENABLE)
		begin
			hit = 1'b1;
		end
		else if (addr == hub_cfg_pkg::OFF_RESERVED_E0)
		begin
			hit = 1'b1;
		end
		else if (addr >= hub_cfg_pkg::OFF_RESERVED_F5)
		begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	function automatic logic [7:0] rom_default(input logic [7:0] addr);
		logic [7:0] value;
		value = hub_cfg_pkg::DEF_ZERO;
		unique case (addr)
			hub_cfg_pkg::OFF_VENDOR_ID_LOW: value = hub_cfg_pkg::DEF_VENDOR_ID_LOW;
			hub_cfg_pkg::OFF_VENDOR_ID_HIGH: value = hub_cfg_pkg::DEF_VENDOR_ID_HIGH;
			hub_cfg_pkg::OFF_PRODUCT_ID_LOW: value = hub_cfg_pkg::DEF_PRODUCT_ID_LOW;
			hub_cfg_pkg::OFF_PRODUCT_ID_HIGH: value = hub_cfg_pkg::DEF_PRODUCT_ID_HIGH;
			hub_cfg_pkg::OFF_RELEASE_NUMBER_LOW: value = hub_cfg_pkg::DEF_RELEASE_NUMBER_LOW;
			hub_cfg_pkg::OFF_RELEASE_NUMBER_HIGH: value = hub_cfg_pkg::DEF_RELEASE_NUMBER_HIGH;
			hub_cfg_pkg::OFF_CONFIG_BYTE_ONE: value = hub_cfg_pkg::DEF_CONFIG_BYTE_ONE;
			hub_cfg_pkg::OFF_CONFIG_BYTE_TWO: value = hub_cfg_pkg::DEF_CONFIG_BYTE_TWO;
			hub_cfg_pkg::OFF_CONFIG_BYTE_THREE: value = hub_cfg_pkg::DEF_CONFIG_BYTE_THREE;
			hub_cfg_pkg::OFF_POWER_BUDGET_SELF: value = hub_cfg_pkg::DEF_POWER_BUDGET_SELF;
			hub_cfg_pkg::OFF_POWER_BUDGET_BUS: value = hub_cfg_pkg::DEF_POWER_BUDGET_BUS;
			hub_cfg_pkg::OFF_CONTROLLER_CURRENT_SELF:
				value = hub_cfg_pkg::DEF_CONTROLLER_CURRENT_SELF;
			hub_cfg_pkg::OFF_CONTROLLER_CURRENT_BUS:
				value = hub_cfg_pkg::DEF_CONTROLLER_CURRENT_BUS;
			hub_cfg_pkg::OFF_PORT_POWER_SETTLE_TIME:
				value = hub_cfg_pkg::DEF_PORT_POWER_SETTLE_TIME;
			default: value = hub_cfg_pkg::DEF_ZERO;
		endcase
		return value;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [1:0] select_meta_q;
	logic [1:0] select_sync_q;
	logic [hub_cfg_pkg::NUM_PORTS-1:0] strap_meta_q;
	logic [hub_cfg_pkg::NUM_PORTS-1:0] strap_sync_q;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			select_meta_q <= 2'h0;
			select_sync_q <= 2'h0;
			strap_meta_q <= '0;
			strap_sync_q <= '0;
		end
		else
		begin
			select_meta_q <= config_select_pin;
			select_sync_q <= select_meta_q;
			strap_meta_q <= strap_charge_pin;
			strap_sync_q <= strap_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Start-up sequence

	hub_cfg_pkg::init_state_type state_q;
	hub_cfg_pkg::init_state_type state_d;
	logic [3:0] settle_q;
	logic [3:0] settle_d;
	hub_cfg_pkg::cfg_source_type source_q;
	hub_cfg_pkg::cfg_source_type source_d;
	logic external_path;

	assign external_path = (source_q == hub_cfg_pkg::SRC_SMBUS) ||
		(source_q == hub_cfg_pkg::SRC_EEPROM);

	always_comb
	begin
		state_d = state_q;
		settle_d = settle_q;
		source_d = source_q;
		unique case (state_q)
			hub_cfg_pkg::ST_SETTLE:
			begin
				settle_d = settle_q + 4'h1;
				if (settle_q == hub_cfg_pkg::SETTLE_CYCLES)
				begin
					state_d = hub_cfg_pkg::ST_APPLY;
					source_d = hub_cfg_pkg::cfg_source_type'(select_sync_q);
				end
			end
			hub_cfg_pkg::ST_APPLY:
			begin
				state_d = hub_cfg_pkg::ST_RUN;
			end
			hub_cfg_pkg::ST_RUN:
			begin
				state_d = hub_cfg_pkg::ST_RUN;
			end
			default:
			begin
				state_d = hub_cfg_pkg::ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q <= hub_cfg_pkg::ST_SETTLE;
			settle_q <= 4'h0;
			source_q <= hub_cfg_pkg::SRC_INTERNAL;
		end
		else
		begin
			state_q <= state_d;
			settle_q <= settle_d;
			source_q <= source_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register storage

	logic [7:0] mem_q [0:hub_cfg_pkg::MAP_SIZE-1];
	logic [7:0] mem_d [0:hub_cfg_pkg::MAP_SIZE-1];
	logic write_take;
	logic status_locked;

	assign status_locked = (request.addr == hub_cfg_pkg::OFF_SMBUS_STATE_AND_COMMAND) &&
		(source_q != hub_cfg_pkg::SRC_SMBUS);

	assign write_take = (state_q == hub_cfg_pkg::ST_RUN) && external_path &&
		request.valid && request.write && is_mapped(request.addr) && !status_locked;

	always_comb
	begin
		for (int i = 0; i < hub_cfg_pkg::MAP_SIZE; i++)
		begin
			mem_d[i] = mem_q[i];
		end
		if (state_q == hub_cfg_pkg::ST_APPLY)
		begin
			for (int i = 0; i < hub_cfg_pkg::MAP_SIZE; i++)
			begin
				mem_d[i] = external_path ? hub_cfg_pkg::DEF_ZERO : rom_default(8'(i));
			end
			if (source_q == hub_cfg_pkg::SRC_BUS_POWERED)
			begin
				mem_d[hub_cfg_pkg::OFF_CONFIG_BYTE_ONE][hub_cfg_pkg::SELF_POWER_BIT] = 1'b0;
			end
			if (!external_path)
			begin
				mem_d[hub_cfg_pkg::OFF_CHARGE_PORT_ENABLE] = {3'h0, strap_sync_q, 1'b0};
			end
		end
		else if (write_take)
		begin
			mem_d[request.addr] = request.wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < hub_cfg_pkg::MAP_SIZE; i++)
			begin
				mem_q[i] <= 8'h00;
			end
		end
		else
		begin
			for (int i = 0; i < hub_cfg_pkg::MAP_SIZE; i++)
			begin
				mem_q[i] <= mem_d[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read answer and outputs

	hub_cfg_pkg::cfg_answer_type answer_q;
	hub_cfg_pkg::cfg_answer_type answer_d;
	hub_cfg_pkg::identity_type identity_q;
	hub_cfg_pkg::identity_type identity_d;
	hub_cfg_pkg::hub_settings_type settings_q;
	hub_cfg_pkg::hub_settings_type settings_d;
	logic [hub_cfg_pkg::NUM_PORTS-1:0] power_q;
	logic [hub_cfg_pkg::NUM_PORTS-1:0] power_d;
	logic done_q;
	logic done_d;

	always_comb
	begin
		answer_d.valid = (state_q == hub_cfg_pkg::ST_RUN) && external_path &&
			request.valid && !request.write;
		answer_d.rdata = 8'h00;
		if (answer_d.valid && is_mapped(request.addr))
		begin
			answer_d.rdata = mem_q[request.addr];
		end
		identity_d.vendor_id = {mem_q[hub_cfg_pkg::OFF_VENDOR_ID_HIGH],
			mem_q[hub_cfg_pkg::OFF_VENDOR_ID_LOW]};
		identity_d.product_id = {mem_q[hub_cfg_pkg::OFF_PRODUCT_ID_HIGH],
			mem_q[hub_cfg_pkg::OFF_PRODUCT_ID_LOW]};
		identity_d.release_number = {mem_q[hub_cfg_pkg::OFF_RELEASE_NUMBER_HIGH],
			mem_q[hub_cfg_pkg::OFF_RELEASE_NUMBER_LOW]};
		settings_d.config_byte_one = mem_q[hub_cfg_pkg::OFF_CONFIG_BYTE_ONE];
		settings_d.config_byte_two = mem_q[hub_cfg_pkg::OFF_CONFIG_BYTE_TWO];
		settings_d.config_byte_three = mem_q[hub_cfg_pkg::OFF_CONFIG_BYTE_THREE];
		settings_d.fixed_attach_ports = mem_q[hub_cfg_pkg::OFF_FIXED_ATTACH_PORTS];
		settings_d.port_off_self_powered = mem_q[hub_cfg_pkg::OFF_PORT_OFF_SELF_POWERED];
		settings_d.port_off_bus_powered = mem_q[hub_cfg_pkg::OFF_PORT_OFF_BUS_POWERED];
		settings_d.power_budget_self = mem_q[hub_cfg_pkg::OFF_POWER_BUDGET_SELF];
		settings_d.power_budget_bus = mem_q[hub_cfg_pkg::OFF_POWER_BUDGET_BUS];
		settings_d.controller_current_self = mem_q[hub_cfg_pkg::OFF_CONTROLLER_CURRENT_SELF];
		settings_d.controller_current_bus = mem_q[hub_cfg_pkg::OFF_CONTROLLER_CURRENT_BUS];
		settings_d.port_power_settle_time = mem_q[hub_cfg_pkg::OFF_PORT_POWER_SETTLE_TIME];
		settings_d.language_code = {mem_q[hub_cfg_pkg::OFF_LANGUAGE_CODE_HIGH],
			mem_q[hub_cfg_pkg::OFF_LANGUAGE_CODE_LOW]};
		settings_d.upstream_drive_strength = mem_q[hub_cfg_pkg::OFF_UPSTREAM_DRIVE_STRENGTH];
		settings_d.downstream_drive_strength =
			mem_q[hub_cfg_pkg::OFF_DOWNSTREAM_DRIVE_STRENGTH];
		settings_d.pair_polarity_swap = mem_q[hub_cfg_pkg::OFF_PAIR_POLARITY_SWAP];
		settings_d.logical_port_remap_a = mem_q[hub_cfg_pkg::OFF_LOGICAL_PORT_REMAP_A];
		settings_d.logical_port_remap_b = mem_q[hub_cfg_pkg::OFF_LOGICAL_PORT_REMAP_B];
		settings_d.smbus_state_and_command = mem_q[hub_cfg_pkg::OFF_SMBUS_STATE_AND_COMMAND];
		done_d = (state_q == hub_cfg_pkg::ST_RUN);
		// charge bit n+1 drives port n once configured
		power_d = done_d ? mem_q[hub_cfg_pkg::OFF_CHARGE_PORT_ENABLE][hub_cfg_pkg::NUM_PORTS:1]
			: '0;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			answer_q <= '0;
			identity_q <= '0;
			settings_q <= '0;
			power_q <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			answer_q <= answer_d;
			identity_q <= identity_d;
			settings_q <= settings_d;
			power_q <= power_d;
			done_q <= done_d;
		end
	end

	assign answer = answer_q;
	assign identity = identity_q;
	assign settings = settings_q;
	assign port_power_out = power_q;
	assign config_done = done_q;
	assign config_source = source_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking chk_clk @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	sequence apply_step;
		state_q == hub_cfg_pkg::ST_APPLY;
	endsequence

	sequence external_apply;
		apply_step and external_path;
	endsequence

	sequence mapped_read;
		state_q == hub_cfg_pkg::ST_RUN && external_path && request.valid && !request.write;
	endsequence

	read_answer_a: assert property (
		mapped_read and is_mapped(request.addr) |=> answer.valid &&
			answer.rdata == $past(mem_q[request.addr]))
		else $error("read answer wrong");

	write_lands_a: assert property (
		write_take |=> mem_q[$past(request.addr)] == $past(request.wdata))
		else $error("written byte not stored");

	eeprom_zero_a: assert property (
		external_apply |=> mem_q[hub_cfg_pkg::OFF_CONFIG_BYTE_ONE] == 8'h00 &&
			mem_q[hub_cfg_pkg::OFF_PORT_POWER_SETTLE_TIME] == 8'h00)
		else $error("external source not zeroed");

	status_excluded_a: assert property (
		state_q == hub_cfg_pkg::ST_RUN && source_q == hub_cfg_pkg::SRC_EEPROM |=>
			$stable(mem_q[hub_cfg_pkg::OFF_SMBUS_STATE_AND_COMMAND]))
		else $error("status byte changed by EEPROM");

	vendor_pair_a: assert property (
		##1 identity.vendor_id == $past({mem_q[hub_cfg_pkg::OFF_VENDOR_ID_HIGH],
			mem_q[hub_cfg_pkg::OFF_VENDOR_ID_LOW]}))
		else $error("vendor identifier order");

	product_pair_a: assert property (
		##1 identity.product_id[7:0] == $past(mem_q[hub_cfg_pkg::OFF_PRODUCT_ID_LOW]) &&
			identity.product_id[15:8] == $past(mem_q[hub_cfg_pkg::OFF_PRODUCT_ID_HIGH]))
		else $error("product identifier order");

	release_pair_a: assert property (
		##1 identity.release_number[15:8] ==
			$past(mem_q[hub_cfg_pkg::OFF_RELEASE_NUMBER_HIGH]) &&
			identity.release_number[7:0] ==
			$past(mem_q[hub_cfg_pkg::OFF_RELEASE_NUMBER_LOW]))
		else $error("release number order");

	charge_power_a: assert property (
		state_q == hub_cfg_pkg::ST_RUN |=> port_power_out ==
			$past(mem_q[hub_cfg_pkg::OFF_CHARGE_PORT_ENABLE][hub_cfg_pkg::NUM_PORTS:1]))
		else $error("port power mismatch");

	bus_override_a: assert property (
		apply_step and source_q == hub_cfg_pkg::SRC_BUS_POWERED |=>
			mem_q[hub_cfg_pkg::OFF_CONFIG_BYTE_ONE] == 8'h1b ##1 config_done)
		else $error("bus-powered override wrong");

	strap_ignored_a: assert property (
		external_apply |=> mem_q[hub_cfg_pkg::OFF_CHARGE_PORT_ENABLE] == 8'h00)
		else $error("strap used under external source");

	unmapped_read_a: assert property (
		mapped_read and !is_mapped(request.addr) |=> answer.valid && answer.rdata == 8'h00)
		else $error("unmapped read not zero");

endmodule

`default_nettype wire

// File: tb/cfg_host_model.sv
/*
 * Model of the configuring party: an SMBus host or the EEPROM loader on the
 * byte-wide register access port.
 * Assumes requests are taken on the rising clk_sys edge and that a read answer is
 * registered on that same taking edge.
 */
`timescale 1ns/1ns
`default_nettype none

module cfg_host_model (
	input wire logic clk_sys,
	output hub_cfg_pkg::cfg_request_type request,
	input wire hub_cfg_pkg::cfg_answer_type answer
);

	initial
	begin
		request = '0;
	end

	////////////////////////////////////////////////////////////////////////////
	// A released port shows the inverse of the last access, not its value
	task automatic release_bus();
	begin
		request.valid = 1'b0;
		request.write = ~request.write;
		request.addr = ~request.addr;
		request.wdata = ~request.wdata;
	end
	endtask

	task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
	begin
		@(posedge clk_sys);
		#1;
		request = '{valid: 1'b1, write: 1'b1, addr: a, wdata: d};
		@(posedge clk_sys);
		#1;
		release_bus();
	end
	endtask

	task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic got);
	begin
		@(posedge clk_sys);
		#1;
		request = '{valid: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk_sys);
		#1;
		got = answer.valid;
		d = answer.rdata;
		release_bus();
	end
	endtask

	task automatic clear_reserved();
	begin
		write_byte(8'he0, 8'h00);
		write_byte(8'hf5, 8'h00);
		write_byte(8'hf7, 8'h00);
		write_byte(8'hf9, 8'h00);
		write_byte(8'hfd, 8'h00);
		write_byte(8'hfe, 8'h00);
	end
	endtask

	task automatic probe_unmapped(input logic [7:0] a);
		logic [7:0] d;
		logic got;
	begin
		read_byte(a, d, got);
	end
	endtask

endmodule

`default_nettype wire

// File: tb/hub_config_register_set_tb.sv
/*
 * Self-checking testbench for the hub configuration register set.
 * Assumes cfg_host_model drives the access port; select and strap pins are
 * driven here, 1 ns after the rising edge.
 */
`timescale 1ns/1ns
`default_nettype none

module hub_config_register_set_tb;

	logic clk_sys;
	logic reset_n;
	logic [1:0] config_select_pin;
	logic [3:0] strap_charge_pin;
	hub_cfg_pkg::cfg_request_type request;
	hub_cfg_pkg::cfg_answer_type answer;
	hub_cfg_pkg::identity_type identity;
	hub_cfg_pkg::hub_settings_type settings;
	logic [3:0] port_power_out;
	logic config_done;
	hub_cfg_pkg::cfg_source_type config_source;
	int miscompares;
	int n_checks;

	hub_config_register_set dut (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.config_select_pin(config_select_pin),
		.strap_charge_pin(strap_charge_pin),
		.request(request),
		.answer(answer),
		.identity(identity),
		.settings(settings),
		.port_power_out(port_power_out),
		.config_done(config_done),
		.config_source(config_source)
	);

	cfg_host_model host (
		.clk_sys(clk_sys),
		.request(request),
		.answer(answer)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
	begin
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	end
	endtask

	task automatic close_out();
	begin
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask

	function automatic logic [7:0] pat(input logic [7:0] a);
		return a ^ 8'hc3;
	endfunction

	task automatic start(input logic [1:0] sel, input logic [3:0] straps);
	begin
		reset_n = 1'b0;
		config_select_pin = sel;
		strap_charge_pin = straps;
		repeat (8) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		for (int i = 0; i < 20 && config_done !== 1'b1; i++)
		begin
			@(posedge clk_sys);
			#1;
		end
		check("config_done", 16'h0001, 16'(config_done));
		check("config_source", 16'(sel), 16'(config_source));
	end
	endtask

	task automatic rd_check(input string name, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic got;
	begin
		host.read_byte(a, d, got);
		check({name, " valid"}, 16'h0001, 16'(got));
		check(name, 16'(exp), 16'(d));
	end
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_internal();
		logic [7:0] d;
		logic got;
	begin
		start(2'h0, 4'b1010);
		check("cfg1", 16'h009b, 16'(settings.config_byte_one));
		check("power", 16'h000a, 16'(port_power_out));
		check("vendor default", {hub_cfg_pkg::DEF_VENDOR_ID_HIGH,
			hub_cfg_pkg::DEF_VENDOR_ID_LOW}, identity.vendor_id);
		check("settle default", 16'(hub_cfg_pkg::DEF_PORT_POWER_SETTLE_TIME),
			16'(settings.port_power_settle_time));
		host.read_byte(8'h06, d, got);
		check("refused", 16'h0000, 16'(got));
		start(2'h2, 4'b0000);
		check("cfg1 bus", 16'h001b, 16'(settings.config_byte_one));
		$display("test internal done");
	end
	endtask

	task automatic t_eeprom();
		logic [7:0] addrs [18];
	begin
		addrs = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h10, 8'h16,
			8'h53, 8'h54, 8'h92, 8'hcf, 8'hd0, 8'hf6, 8'hf8, 8'hfa, 8'hfc};
		start(2'h3, 4'b1111);
		check("vendor zero", 16'h0000, identity.vendor_id);
		check("cfg1 zero", 16'h0000, 16'(settings.config_byte_one));
		check("straps off", 16'h0000, 16'(port_power_out));
		foreach (addrs[i])
			host.write_byte(addrs[i], pat(addrs[i]));
		foreach (addrs[i])
			rd_check("byte", addrs[i], pat(addrs[i]));
		check("vendor", {pat(8'h01), pat(8'h00)}, identity.vendor_id);
		check("product", {pat(8'h03), pat(8'h02)}, identity.product_id);
		check("release", {pat(8'h05), pat(8'h04)}, identity.release_number);
		check("cfg1", 16'(pat(8'h06)), 16'(settings.config_byte_one));
		check("charge", 16'((pat(8'hd0) >> 1) & 8'h0f), 16'(port_power_out));
		host.write_byte(8'hff, 8'h55);
		rd_check("status eeprom", 8'hff, 8'h00);
		host.write_byte(8'hd5, 8'hff);
		host.probe_unmapped(8'hd5);
		rd_check("after unmapped", 8'hd0, pat(8'hd0));
		host.write_byte(8'he0, 8'h77);
		rd_check("reserved", 8'he0, 8'h77);
		host.clear_reserved();
		rd_check("reserved zero", 8'he0, 8'h00);
		$display("test eeprom done");
	end
	endtask

	task automatic t_smbus();
	begin
		start(2'h1, 4'b1111);
		check("straps off", 16'h0000, 16'(port_power_out));
		host.write_byte(8'hff, 8'h5a);
		rd_check("status smbus", 8'hff, 8'h5a);
		check("status out", 16'h005a, 16'(settings.smbus_state_and_command));
		host.write_byte(8'h00, 8'h34);
		host.write_byte(8'h01, 8'h12);
		rd_check("vendor high", 8'h01, 8'h12);
		check("vendor smbus", 16'h1234, identity.vendor_id);
		host.write_byte(8'h11, 8'h04);
		host.write_byte(8'h12, 8'h09);
		host.write_byte(8'hd0, 8'h1e);
		rd_check("charge smbus", 8'hd0, 8'h1e);
		check("language", 16'h0409, settings.language_code);
		check("power smbus", 16'h000f, 16'(port_power_out));
		$display("test smbus done");
	end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		reset_n = 1'b0;
		config_select_pin = 2'h0;
		strap_charge_pin = 4'h0;
		miscompares = 0;
		n_checks = 0;
		t_internal();
		t_eeprom();
		t_smbus();
		close_out();
	end

	initial
	begin
		#200000;
		miscompares++;
		close_out();
	end

endmodule

`default_nettype wire
